// ==== src/lec_line_error.sv ====
// Line error detection, 16-bit error counter with auto/manual report,
// interrupt status and transmit error insertion for one channel.
// Assumes decoder, encoder, pattern logic and register port all run on
// i_ref_clk and mark each line bit with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - AMI: same-polarity successive pulses flag bipolar violation
// - HDB3/B8ZS: illegal substitution violation flags code violation
// - Config bit picks ANSI/FCC; pin mode forces ANSI
// - AMI excess zeros: over 15 ANSI, 80 FCC
// - HDB3 over 3 zeros, B8ZS over 7
// - Two-bit select; 11 counts violations plus zeros
// - Select 00 counts pattern logic errors
// - Selected errors accumulate in 16-bit counter
// - Each error sets status flag; interrupt unless masked
// - Single rail: violation output high one bit period
// - Mode bit: 1 auto per second, 0 manual
// - Auto: each second copy, clear, keep counting
// - Errors during transfer go to next interval
// - Second expiry sets flag; interrupt when unmasked
// - Reading status register clears timer flag
// - Counter overflow sets flag; interrupt unless masked
// - Manual: trigger rising edge copies, then clears
// - Insert rising edge inverts middle of three marks
// - Logic insert rising edge during active pattern corrupts one pattern bit
module lec_line_error
  import lec_pkg::*;
#(
  parameter int T1_TICKS = T1_SECOND_TICKS,
  parameter int E1_TICKS = E1_SECOND_TICKS
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire lec_reg_req_type   i_reg_req,
  output logic [7:0]             o_reg_rdata,
  input  wire lec_line_code_type i_line_code,
  input  wire logic              i_hw_ctrl,
  input  wire logic              i_single_rail,
  input  wire logic              i_e1_mode,
  input  wire logic              i_mclk_tick,
  input  wire lec_symbol_type    i_rx_sym,
  input  wire logic              i_pattern_err,
  input  wire lec_symbol_type    i_tx_sym,
  input  wire logic              i_pattern_tx_active,
  input  wire logic              i_pattern_tx_bit,
  output lec_symbol_type         o_tx_sym,
  output logic                   o_pattern_tx_bit,
  output logic                   o_violation_pulse_out,
  output logic                   o_int_req
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0]  error_counter_config;
  logic [7:0]  interrupt_mask_second;
  logic [7:0]  interrupt_status_second;
  logic [15:0] error_count_result;
  logic [15:0] error_count;
  logic [7:0]  next_config;
  logic        cfg_wr;
  logic        status_rd;

  assign cfg_wr    = i_reg_req.wr &&
                     (i_reg_req.addr == ADDR_ERROR_COUNTER_CONFIG);
  assign status_rd = i_reg_req.rd &&
                     (i_reg_req.addr == ADDR_INTERRUPT_STATUS_SECOND);
  assign next_config = i_reg_req.wdata;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      error_counter_config  <= CONFIG_RESET;
      interrupt_mask_second <= MASK_RESET;
    end else if (i_reg_req.wr) begin
      if (cfg_wr) begin
        error_counter_config <= next_config;
      end
      if (i_reg_req.addr == ADDR_INTERRUPT_MASK_SECOND) begin
        interrupt_mask_second <= i_reg_req.wdata;
      end
    end
  end

  // Rising edges written to the trigger bits
  logic trf_rise;
  logic violation_insert_trigger_rise;
  logic err_ins_rise;
  assign trf_rise = cfg_wr &&
      next_config[CFG_MANUAL_TRANSFER_TRIGGER] &&
      !error_counter_config[CFG_MANUAL_TRANSFER_TRIGGER];
  assign violation_insert_trigger_rise = cfg_wr &&
      next_config[CFG_VIOLATION_INSERT_TRIGGER] &&
      !error_counter_config[CFG_VIOLATION_INSERT_TRIGGER];
  assign err_ins_rise = cfg_wr &&
      next_config[CFG_LOGIC_ERROR_INSERT_TRIGGER] &&
      !error_counter_config[CFG_LOGIC_ERROR_INSERT_TRIGGER];

  logic              auto_mode;
  logic              fcc_sel;
  lec_error_sel_type err_sel;
  assign auto_mode = error_counter_config[CFG_REPORT_MODE_SEL];
  assign fcc_sel   = error_counter_config[CFG_ZERO_LIMIT_STANDARD_SEL] &&
                     !i_hw_ctrl;
  assign err_sel   = lec_error_sel_type'(
      error_counter_config[CFG_ERROR_SEL_LSB +: 2]);

  // ==========================================================
  // Receive violation and excess-zero detection
  // ==========================================================
  logic       rx_mark;
  logic       last_pol;
  logic       last_v_pol;
  logic [6:0] zero_run;
  logic [1:0] since_v;
  logic       bipolar_violation_error;
  logic       viol_err;
  logic       zero_err;
  logic [6:0] zero_limit;

  assign rx_mark = i_rx_sym.pos || i_rx_sym.neg;
  assign bipolar_violation_error = i_rx_sym.valid && rx_mark &&
               (i_rx_sym.pos == last_pol);

  always_comb begin
    viol_err = 1'b0;
    unique case (i_line_code)
      LINE_AMI: viol_err = bipolar_violation_error;
      LINE_HDB3: viol_err = bipolar_violation_error &&
          ((zero_run < HDB3_ZEROS_BEFORE_V) ||
           (i_rx_sym.pos == last_v_pol));
      LINE_B8ZS: viol_err = bipolar_violation_error &&
          !((zero_run == B8ZS_ZEROS_BEFORE_V1) ||
            ((zero_run == B8ZS_ZEROS_BEFORE_V2) &&
             (since_v == B8ZS_V_SPACING)));
      default: viol_err = bipolar_violation_error;
    endcase
  end

  always_comb begin
    zero_limit = ZERO_LIMIT_AMI_ANSI;
    unique case (i_line_code)
      LINE_AMI:  zero_limit = fcc_sel ? ZERO_LIMIT_AMI_FCC
                                      : ZERO_LIMIT_AMI_ANSI;
      LINE_HDB3: zero_limit = ZERO_LIMIT_HDB3;
      LINE_B8ZS: zero_limit = ZERO_LIMIT_B8ZS;
      default:   zero_limit = ZERO_LIMIT_AMI_ANSI;
    endcase
  end

  // Fires once per run, on the zero that passes the limit
  assign zero_err = i_rx_sym.valid && !rx_mark &&
                    (zero_run == zero_limit);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      last_pol   <= 1'b0;
      last_v_pol <= 1'b0;
      zero_run   <= 7'h00;
      since_v    <= 2'h0;
    end else if (i_rx_sym.valid) begin
      if (rx_mark) begin
        last_pol <= i_rx_sym.pos;
        zero_run <= 7'h00;
        if (bipolar_violation_error) begin
          last_v_pol <= i_rx_sym.pos;
          since_v    <= 2'h0;
        end else if (since_v != 2'h3) begin
          since_v <= since_v + 2'h1;
        end
      end else begin
        if (zero_run != 7'h7f) begin
          zero_run <= zero_run + 7'h01;
        end
        if (since_v != 2'h3) begin
          since_v <= since_v + 2'h1;
        end
      end
    end
  end

  // Violation output stands from one bit strobe to the next
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_violation_pulse_out <= 1'b0;
    end else if (i_rx_sym.valid) begin
      o_violation_pulse_out <= viol_err && i_single_rail;
    end
  end

  // ==========================================================
  // One-second timer
  // ==========================================================
  logic [21:0] sec_cnt;
  logic [21:0] sec_last;
  logic        sec_expire;
  assign sec_last = i_e1_mode ? 22'(E1_TICKS - 1)
                              : 22'(T1_TICKS - 1);
  assign sec_expire = auto_mode && i_mclk_tick &&
                      (sec_cnt >= sec_last);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || !auto_mode) begin
      sec_cnt <= 22'h000000;
    end else if (i_mclk_tick) begin
      sec_cnt <= sec_expire ? 22'h000000 : sec_cnt + 22'h000001;
    end
  end

  // ==========================================================
  // Error counter and report transfer
  // ==========================================================
  logic [1:0]  inc;
  logic        transfer;
  logic [16:0] sum;
  logic        overflow;

  always_comb begin
    inc = 2'h0;
    unique case (err_sel)
      SEL_PATTERN: inc = {1'b0, i_pattern_err};
      SEL_VIOL:    inc = {1'b0, viol_err};
      SEL_ZERO:    inc = {1'b0, zero_err};
      SEL_BOTH:    inc = {1'b0, viol_err} + {1'b0, zero_err};
    endcase
  end

  // Auto transfers on expiry, manual on a written rising edge
  assign transfer = auto_mode ? sec_expire
                              : trf_rise;
  assign sum = {1'b0, error_count} + {15'h0000, inc};
  assign overflow = sum[16] && !transfer;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      error_count        <= 16'h0000;
      error_count_result <= 16'h0000;
    end else if (transfer) begin
      error_count_result <= error_count;
      error_count        <= {14'h0000, inc};
    end else if (sum[16]) begin
      error_count <= 16'hffff;
    end else begin
      error_count <= sum[15:0];
    end
  end

  // ==========================================================
  // Interrupt status: set wins over read clear
  // ==========================================================
  logic [7:0] status_set;
  always_comb begin
    status_set = 8'h00;
    status_set[ST_CODE_VIOLATION_ERROR] = viol_err;
    status_set[ST_EXCESS_ZERO_ERROR]    = zero_err;
    status_set[ST_PATTERN_LOGIC_ERROR]  = i_pattern_err;
    status_set[ST_SECOND_TIMER_EXPIRED] = sec_expire;
    status_set[ST_COUNTER_OVERFLOW]     = overflow;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      interrupt_status_second <= STATUS_RESET;
    end else if (status_rd) begin
      interrupt_status_second <= status_set;
    end else begin
      interrupt_status_second <= interrupt_status_second | status_set;
    end
  end

  assign o_int_req = |(interrupt_status_second &
                       ~interrupt_mask_second);

  // ==========================================================
  // Register read data
  // ==========================================================
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      unique case (i_reg_req.addr)
        ADDR_ERROR_COUNTER_CONFIG:
          o_reg_rdata <= error_counter_config;
        ADDR_INTERRUPT_MASK_SECOND:
          o_reg_rdata <= interrupt_mask_second;
        ADDR_INTERRUPT_STATUS_SECOND:
          o_reg_rdata <= interrupt_status_second;
        ADDR_ERROR_COUNT_RESULT_FIRST:
          o_reg_rdata <= error_count_result[7:0];
        ADDR_ERROR_COUNT_RESULT_SECOND:
          o_reg_rdata <= error_count_result[15:8];
        default:
          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Transmit bipolar violation insertion
  // ==========================================================
  lec_symbol_type tx_d0;
  lec_symbol_type tx_d1;
  logic           bpv_armed;
  logic           three_marks;

  // Incoming, tx_d0 and tx_d1 all marks; tx_d0 is the middle one
  assign three_marks = (i_tx_sym.pos || i_tx_sym.neg) &&
                       (tx_d0.pos || tx_d0.neg) &&
                       (tx_d1.pos || tx_d1.neg);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      bpv_armed <= 1'b0;
      tx_d0     <= '0;
      tx_d1     <= '0;
      o_tx_sym  <= '0;
    end else begin
      o_tx_sym.valid <= i_tx_sym.valid;
      if (i_tx_sym.valid) begin
        o_tx_sym.pos <= tx_d1.pos;
        o_tx_sym.neg <= tx_d1.neg;
        tx_d0        <= i_tx_sym;
        if (bpv_armed && three_marks) begin
          tx_d1.valid <= tx_d0.valid;
          tx_d1.pos   <= tx_d0.neg;
          tx_d1.neg   <= tx_d0.pos;
          bpv_armed   <= violation_insert_trigger_rise;
        end else begin
          tx_d1     <= tx_d0;
          bpv_armed <= bpv_armed || violation_insert_trigger_rise;
        end
      end else begin
        bpv_armed <= bpv_armed || violation_insert_trigger_rise;
      end
    end
  end

  // ==========================================================
  // Transmit pattern logic error insertion
  // ==========================================================
  logic err_armed;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      err_armed        <= 1'b0;
      o_pattern_tx_bit <= 1'b0;
    end else if (i_tx_sym.valid && i_pattern_tx_active) begin
      o_pattern_tx_bit <= i_pattern_tx_bit ^ err_armed;
      err_armed        <= err_ins_rise;
    end else begin
      if (i_tx_sym.valid) begin
        o_pattern_tx_bit <= i_pattern_tx_bit;
      end
      err_armed <= (err_armed || err_ins_rise) &&
                   i_pattern_tx_active;
    end
  end

endmodule // lec_line_error

`default_nettype wire

// ==== src/lec_pkg.sv ====
// Package for the line error count and insert block: register map,
// field positions, reset values, code limits and struct carriers.
// Assumes the register port, decoder and encoder share one clock.
package lec_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_ERROR_COUNTER_CONFIG     = 8'h12;
  localparam logic [7:0] ADDR_INTERRUPT_MASK_SECOND    = 8'h14;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS_SECOND  = 8'h19;
  localparam logic [7:0] ADDR_ERROR_COUNT_RESULT_FIRST = 8'h1a;
  localparam logic [7:0] ADDR_ERROR_COUNT_RESULT_SECOND = 8'h1b;

  // Fields of error_counter_config
  localparam int CFG_ZERO_LIMIT_STANDARD_SEL   = 0;
  localparam int CFG_REPORT_MODE_SEL           = 1;
  localparam int CFG_MANUAL_TRANSFER_TRIGGER   = 2;
  localparam int CFG_VIOLATION_INSERT_TRIGGER  = 3;
  localparam int CFG_LOGIC_ERROR_INSERT_TRIGGER = 4;
  localparam int CFG_ERROR_SEL_LSB             = 5;

  // Fields of interrupt status and mask
  localparam int ST_CODE_VIOLATION_ERROR   = 0;
  localparam int ST_EXCESS_ZERO_ERROR      = 1;
  localparam int ST_PATTERN_LOGIC_ERROR    = 2;
  localparam int ST_SECOND_TIMER_EXPIRED   = 3;
  localparam int ST_COUNTER_OVERFLOW       = 4;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Excess-zero limits: error on the run that exceeds the limit
  localparam logic [6:0] ZERO_LIMIT_AMI_ANSI = 7'h0f;
  localparam logic [6:0] ZERO_LIMIT_AMI_FCC  = 7'h50;
  localparam logic [6:0] ZERO_LIMIT_HDB3     = 7'h03;
  localparam logic [6:0] ZERO_LIMIT_B8ZS     = 7'h07;

  // Zero run that legally precedes a substitution violation
  localparam logic [6:0] HDB3_ZEROS_BEFORE_V  = 7'h02;
  localparam logic [6:0] B8ZS_ZEROS_BEFORE_V1 = 7'h03;
  localparam logic [6:0] B8ZS_ZEROS_BEFORE_V2 = 7'h01;
  localparam logic [1:0] B8ZS_V_SPACING       = 2'h3;

  // One-second reporting period in master clock ticks
  localparam int SECOND_S       = 1;
  localparam int T1_MCLK_HZ     = 1544000;
  localparam int E1_MCLK_HZ     = 2048000;
  localparam int T1_SECOND_TICKS = SECOND_S * T1_MCLK_HZ;
  localparam int E1_SECOND_TICKS = SECOND_S * E1_MCLK_HZ;

  typedef enum logic [1:0] {
    LINE_AMI  = 2'b00,
    LINE_HDB3 = 2'b01,
    LINE_B8ZS = 2'b10
  } lec_line_code_type;

  typedef enum logic [1:0] {
    SEL_PATTERN = 2'b00,
    SEL_VIOL    = 2'b01,
    SEL_ZERO    = 2'b10,
    SEL_BOTH    = 2'b11
  } lec_error_sel_type;

  // One line symbol, dual rail, with its bit strobe
  typedef struct packed {
    logic valid;
    logic pos;
    logic neg;
  } lec_symbol_type;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lec_reg_req_type;

endpackage

// ==== testbench/lec_line_error_sva.sv ====
// Checker for lec_line_error, sees only the ports of the block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lec_line_error_chk
  import lec_pkg::*;
#(
  parameter int T1_TICKS = T1_SECOND_TICKS,
  parameter int E1_TICKS = E1_SECOND_TICKS
) (
  input wire logic            i_ref_clk,
  input wire logic            i_nrst,
  input wire lec_reg_req_type i_reg_req,
  input wire logic [7:0]      o_reg_rdata,
  input wire logic            i_single_rail,
  input wire logic            i_mclk_tick,
  input wire lec_symbol_type  i_rx_sym,
  input wire logic            i_pattern_err,
  input wire lec_symbol_type  i_tx_sym,
  input wire logic            i_pattern_tx_active,
  input wire logic            i_pattern_tx_bit,
  input wire lec_symbol_type  o_tx_sym,
  input wire logic            o_pattern_tx_bit,
  input wire logic            o_violation_pulse_out,
  input wire logic            o_int_req
);
  // ==========================================================
  // Access decoding
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  logic rd_status;
  logic mapped;
  assign rd_status = i_reg_req.rd &&
                     i_reg_req.addr == ADDR_INTERRUPT_STATUS_SECOND;
  assign mapped = i_reg_req.addr inside {ADDR_ERROR_COUNTER_CONFIG,
    ADDR_INTERRUPT_MASK_SECOND, ADDR_INTERRUPT_STATUS_SECOND,
    ADDR_ERROR_COUNT_RESULT_FIRST, ADDR_ERROR_COUNT_RESULT_SECOND};
  sequence cfg_write;
    i_reg_req.wr && i_reg_req.addr == ADDR_ERROR_COUNTER_CONFIG;
  endsequence
  sequence cfg_read;
    i_reg_req.rd && i_reg_req.addr == ADDR_ERROR_COUNTER_CONFIG;
  endsequence
  sequence status_twice;
    rd_status ##3 rd_status;
  endsequence

  // ==========================================================
  // Properties
  reset_quiet_a: assert property (
    $rose(i_nrst) |-> !o_int_req && !o_violation_pulse_out)
    else $error("outputs not quiet after reset");
  cfg_readback_a: assert property (
    cfg_write ##2 cfg_read |=> o_reg_rdata == $past(i_reg_req.wdata, 3))
    else $error("config readback differs");
  unmapped_zero_a: assert property (
    i_reg_req.rd && !mapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  status_clear_a: assert property (
    status_twice |=> !(o_reg_rdata[ST_SECOND_TIMER_EXPIRED] &&
      $past(o_reg_rdata[ST_SECOND_TIMER_EXPIRED], 3)))
    else $error("timer flag survived a read");
  pulse_timing_a: assert property (
    $changed(o_violation_pulse_out) |-> $past(i_rx_sym.valid))
    else $error("violation pulse moved off a bit strobe");
  pulse_gate_a: assert property (
    $rose(o_violation_pulse_out) |-> $past(i_single_rail))
    else $error("violation pulse outside single rail");
  int_cause_a: assert property (
    $rose(o_int_req) |-> $past(i_rx_sym.valid || i_pattern_err ||
      i_reg_req.wr || i_mclk_tick))
    else $error("interrupt rose without cause");
  int_release_a: assert property (
    $fell(o_int_req) |-> $past(i_reg_req.rd || i_reg_req.wr))
    else $error("interrupt fell without access");
  tx_valid_a: assert property (
    o_tx_sym.valid == $past(i_tx_sym.valid))
    else $error("transmit strobe not delayed one cycle");
  pattern_pass_a: assert property (
    i_tx_sym.valid && !i_pattern_tx_active |=>
      o_pattern_tx_bit == $past(i_pattern_tx_bit))
    else $error("pattern bit corrupted while idle");
endmodule // lec_line_error_chk

bind lec_line_error lec_line_error_chk #(
  .T1_TICKS(T1_TICKS), .E1_TICKS(E1_TICKS)
) chk_i (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .i_single_rail(i_single_rail),
  .i_mclk_tick(i_mclk_tick), .i_rx_sym(i_rx_sym),
  .i_pattern_err(i_pattern_err), .i_tx_sym(i_tx_sym),
  .i_pattern_tx_active(i_pattern_tx_active),
  .i_pattern_tx_bit(i_pattern_tx_bit), .o_tx_sym(o_tx_sym),
  .o_pattern_tx_bit(o_pattern_tx_bit),
  .o_violation_pulse_out(o_violation_pulse_out), .o_int_req(o_int_req)
);
`default_nettype wire

// ==== testbench/lec_far_end.sv ====
// Far-end model: receive decoder, transmit encoder, master clock tick.
// Assumes sym() is called from one thread just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module lec_far_end
  import lec_pkg::*;
(
  input  wire logic      i_ref_clk,
  output lec_symbol_type o_rx_sym,
  output lec_symbol_type o_tx_sym,
  output logic           o_mclk_tick
);
  logic rx_last;
  logic tx_last;

  // ==========================================================
  // Symbol source, one bit strobe every four cycles
  initial begin
    o_rx_sym = '0;
    o_tx_sym = '0;
    o_mclk_tick = 1'b0;
    rx_last = 1'b0;
    tx_last = 1'b0;
  end

  always @(posedge i_ref_clk) begin
    o_mclk_tick <= !o_mclk_tick;
  end

  // Kind 0 is a space, 1 a mark of alternate polarity, 2 a repeat
  function automatic lec_symbol_type mk(input logic [1:0] k,
                                        inout logic last);
    lec_symbol_type s;
    if (k == 2'h1) begin
      last = !last;
    end
    s.valid = 1'b1;
    s.pos = (k != 2'h0) && last;
    s.neg = (k != 2'h0) && !last;
    return s;
  endfunction

  task automatic sym(input logic tx, input logic [1:0] k);
    @(posedge i_ref_clk);
    if (tx) begin
      o_tx_sym <= mk(k, tx_last);
    end else begin
      o_rx_sym <= mk(k, rx_last);
    end
    @(posedge i_ref_clk);
    o_rx_sym <= '0;
    o_tx_sym <= '0;
    repeat (2) @(posedge i_ref_clk);
  endtask
endmodule // lec_far_end
`default_nettype wire

// ==== testbench/tb_lec_line_error.sv ====
// Testbench for lec_line_error: registers, receive errors, counting,
// report modes and transmit insertion.
// Assumes lec_far_end supplies line symbols and master clock ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_lec_line_error
  import lec_pkg::*;
;
  logic              clk, nrst, hw, single, err, ptx_act, e1;
  lec_reg_req_type   req;
  logic [7:0]        rdata;
  lec_line_code_type line;
  lec_symbol_type    rxs, txs, otx;
  logic              tick, ptx_out, vpulse, intr;
  int                failures, checked, pulse_cnt, pat_ones;
  logic              marks[$];

  lec_far_end far (.i_ref_clk(clk), .o_rx_sym(rxs), .o_tx_sym(txs),
                   .o_mclk_tick(tick));
  lec_line_error #(.T1_TICKS(20), .E1_TICKS(25)) uut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_line_code(line), .i_hw_ctrl(hw), .i_single_rail(single),
    .i_e1_mode(e1), .i_mclk_tick(tick), .i_rx_sym(rxs),
    .i_pattern_err(err), .i_tx_sym(txs), .i_pattern_tx_active(ptx_act),
    .i_pattern_tx_bit(1'b0), .o_tx_sym(otx), .o_pattern_tx_bit(ptx_out),
    .o_violation_pulse_out(vpulse), .o_int_req(intr));

  // ==========================================================
  // Monitors and bus tasks
  always @(posedge clk) begin
    if (vpulse === 1'b1)
      pulse_cnt++;
    if (otx.valid === 1'b1 && (otx.pos | otx.neg))
      marks.push_back(otx.pos);
    if (otx.valid === 1'b1 && ptx_out === 1'b1)
      pat_ones++;
  end

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    req <= {2'b10, a, d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic cr(input logic [7:0] a, e, input string n);
    @(posedge clk);
    req <= {2'b01, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1 chk(n, {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic wait_int;
    int n;
    n = 0;
    while (intr !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (intr !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    cr(8'h14, MASK_RESET, "mask");
    cr(8'h12, CONFIG_RESET, "config");
    cr(8'h19, STATUS_RESET, "status");
    cr(8'h1a, 8'h00, "result lo");
    cr(8'h1b, 8'h00, "result hi");
    wr(8'h20, 8'h5a);
    cr(8'h20, 8'h00, "unmapped");
    wr(8'h12, 8'h80);
    cr(8'h12, 8'h80, "spare bit");
  endtask

  task automatic t_bpv;
    single <= 1'b1;
    pulse_cnt = 0;
    wr(8'h12, 8'h20);
    wr(8'h14, 8'hfe);
    far.sym(0, 1);
    far.sym(0, 2);
    far.sym(0, 0);
    chk("int", 1, {15'h0, intr});
    chk("pulse", 4, 16'(pulse_cnt));
    cr(8'h19, 8'h01, "status");
    chk("int", 0, {15'h0, intr});
    wr(8'h12, 8'h24);
    cr(8'h1a, 8'h01, "result lo");
    cr(8'h1b, 8'h00, "result hi");
    single <= 1'b0;
    far.sym(0, 2);
    far.sym(0, 0);
    chk("pulse", 4, 16'(pulse_cnt));
    cr(8'h19, 8'h01, "status");
    line <= LINE_HDB3;
    far.sym(0, 2);
    far.sym(0, 0);
    cr(8'h19, 8'h01, "hdb3 illegal");
    far.sym(0, 1);
    repeat (2) far.sym(0, 0);
    far.sym(0, 2);
    cr(8'h19, 8'h00, "hdb3 legal");
    line <= LINE_AMI;
    wr(8'h12, 8'h20);
    wr(8'h12, 8'h24);
    cr(8'h1a, 8'h02, "result lo");
  endtask

  task automatic t_exz;
    lec_line_code_type lc[5];
    int lim[5];
    logic [4:0] fcc;
    logic [4:0] hws;
    lc = '{LINE_AMI, LINE_AMI, LINE_AMI, LINE_HDB3, LINE_B8ZS};
    lim = '{15, 80, 15, 3, 7};
    fcc = 5'b01110;
    hws = 5'b00100;
    wr(8'h14, 8'hff);
    for (int i = 0; i < 5; i++) begin
      line <= lc[i];
      hw <= hws[i];
      wr(8'h12, 8'h40 | {7'h00, fcc[i]});
      far.sym(0, 1);
      repeat (lim[i]) far.sym(0, 0);
      cr(8'h19, 8'h00, "no zero error");
      far.sym(0, 0);
      cr(8'h19, 8'h02, "zero error");
    end
    wr(8'h12, 8'h44);
    cr(8'h1a, 8'h05, "zero count");
    line <= LINE_AMI;
    hw <= 1'b0;
    wr(8'h12, 8'h60);
    far.sym(0, 2);
    repeat (16) far.sym(0, 0);
    wr(8'h12, 8'h64);
    cr(8'h1a, 8'h02, "both count");
    cr(8'h19, 8'h03, "status");
  endtask

  task automatic t_auto;
    wr(8'h14, 8'hf7);
    wr(8'h12, 8'h02);
    repeat (3) begin
      @(posedge clk);
      err <= 1'b1;
      @(posedge clk);
      err <= 1'b0;
    end
    wait_int();
    cr(8'h19, 8'h0c, "status");
    cr(8'h19, 8'h00, "status");
    cr(8'h1a, 8'h03, "result lo");
    cr(8'h1b, 8'h00, "result hi");
    repeat (2) begin
      @(posedge clk);
      err <= 1'b1;
      @(posedge clk);
      err <= 1'b0;
    end
    wait_int();
    cr(8'h19, 8'h0c, "status");
    cr(8'h1a, 8'h02, "result lo");
    wr(8'h12, 8'h00);
    e1 <= 1'b1;
    wr(8'h12, 8'h02);
    repeat (46) @(posedge clk);
    chk("second e1", 16'h0, {15'h0, intr});
    repeat (6) @(posedge clk);
    chk("second e1", 16'h1, {15'h0, intr});
    cr(8'h19, 8'h08, "status");
    wr(8'h12, 8'h00);
  endtask

  task automatic t_ovf;
    wr(8'h14, 8'hef);
    err <= 1'b1;
    repeat (65537) @(posedge clk);
    err <= 1'b0;
    repeat (2) @(posedge clk);
    chk("int", 1, {15'h0, intr});
    cr(8'h19, 8'h14, "status");
    wr(8'h12, 8'h04);
    cr(8'h1a, 8'hff, "result lo");
    cr(8'h1b, 8'hff, "result hi");
    wr(8'h12, 8'h00);
  endtask

  task automatic t_ins;
    marks.delete();
    repeat (3) far.sym(1, 1);
    repeat (3) far.sym(1, 0);
    chk("marks", 3, 16'(marks.size()));
    chk("polarity", 16'h5, {13'h0, marks[0], marks[1], marks[2]});
    wr(8'h12, 8'h08);
    marks.delete();
    repeat (3) far.sym(1, 1);
    repeat (3) far.sym(1, 0);
    chk("marks", 3, 16'(marks.size()));
    chk("polarity", 16'h0, {13'h0, marks[0], marks[1], marks[2]});
    wr(8'h12, 8'h00);
    wr(8'h12, 8'h10);
    pat_ones = 0;
    repeat (4) far.sym(1, 0);
    chk("idle ones", 0, 16'(pat_ones));
    wr(8'h12, 8'h00);
    ptx_act <= 1'b1;
    wr(8'h12, 8'h10);
    pat_ones = 0;
    repeat (4) far.sym(1, 0);
    chk("pattern ones", 1, 16'(pat_ones));
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    line = LINE_AMI;
    hw = 1'b0;
    single = 1'b0;
    err = 1'b0;
    ptx_act = 1'b0;
    e1 = 1'b0;
    failures = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_bpv();
    t_exz();
    t_auto();
    t_ovf();
    t_ins();
    conclude();
  end
endmodule // tb_lec_line_error
`default_nettype wire
